// *** hdl/bids_pkg.sv ***
// Purpose: Shared constants and types for the jump / increment / decrement executor
// Assumes: 8-bit data, 7-bit file address, 13-bit program counter
// Notes: Opcodes are internal decoded operation codes, not instruction encodings
package bids_pkg;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W = 13;
    localparam int LIT_W = 11;
    localparam int LATCH_W = 8;
    localparam int LATCH_LO = 3;
    localparam int LATCH_HI = 4;
    localparam logic [7:0] ONE = 8'h01;
    localparam logic [7:0] ZERO = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;

    typedef enum logic [2:0] {
        BIDS_OP_NONE = 3'b000,
        BIDS_OP_JUMP = 3'b001,
        BIDS_OP_DEC = 3'b010,
        BIDS_OP_INC = 3'b011,
        BIDS_OP_DEC_SKIP = 3'b100,
        BIDS_OP_INC_SKIP = 3'b101
    } bids_op_e;

    typedef enum logic [1:0] {
        BIDS_ST_EXEC = 2'b00,
        BIDS_ST_FLUSH = 2'b01
    } bids_state_e;
endpackage

// *** hdl/bids_alu_if.sv ***
// Purpose: Carrier between the executor and its arithmetic unit
// Assumes: Single clock domain
// Notes: Combinational path only
`timescale 1ns/1ps
interface bids_alu_if;
    logic [7:0] operand;
    logic decrement;
    logic [7:0] result;
    logic is_zero;
    modport ctrl (output operand, output decrement, input result, input is_zero);
    modport alu (input operand, input decrement, output result, output is_zero);
endinterface

// *** hdl/bids_alu.sv ***
// Purpose: Increment or decrement by one, modulo 256, with zero detect
// Assumes: Operand already read from the file register
// Notes: Carry is discarded on purpose
`timescale 1ns/1ps
module bids_alu (
    bids_alu_if.alu port_a
);
    logic [bids_pkg::DATA_W:0] sum;
    always_comb begin
        if (port_a.decrement) begin
            sum = {1'b0, port_a.operand} - {1'b0, bids_pkg::ONE};
        end else begin
            sum = {1'b0, port_a.operand} + {1'b0, bids_pkg::ONE};
        end
    end
    assign port_a.result = sum[bids_pkg::DATA_W-1:0];
    assign port_a.is_zero = (sum[bids_pkg::DATA_W-1:0] == bids_pkg::ZERO);
endmodule

// *** hdl/bids_exec.sv ***
// Purpose: Executes absolute jump, increment, decrement and their skip-on-zero forms
// Assumes: One i_issue pulse per instruction cycle from the fetch unit; file data is
//          presented combinationally with the issue
// Notes: A skip or jump squashes the next issued instruction (flush cycle)
//
// How it works
// - Jump loads the 11-bit literal into program counter bits 10 to 0.
// - Jump fills counter bits 12 and 11 from upper latch bits 4 and 3.
// - Jump takes two instruction cycles and leaves all flags unchanged.
// - Decrement stores file minus one to working or file register, updates zero.
// - Increment stores file plus one to working or file register, updates zero.
// - Decrement-skip stores result, keeps flags, no-operation replaces next if zero.
// - Increment-skip stores result, keeps flags, no-operation replaces next if zero.
// - Nonzero skip-form result lets the next instruction execute normally.
`timescale 1ns/1ps
module bids_exec #(
    parameter int DATA_W = bids_pkg::DATA_W
) (
    // Clock, reset and enable
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_enable,
    // Decoded instruction
    input wire logic i_issue,
    input wire bids_pkg::bids_op_e i_op,
    input wire logic [10:0] i_literal,
    input wire logic [6:0] i_file_addr,
    input wire logic i_dest_file,
    // Operand sources
    input wire logic [DATA_W-1:0] i_file_data,
    input wire logic [7:0] i_pc_upper_latch,
    // Program counter
    output logic o_pc_load,
    output logic [12:0] o_program_counter,
    output logic o_flush,
    // Results
    output logic o_file_we,
    output logic [6:0] o_file_addr,
    output logic [DATA_W-1:0] o_file_wdata,
    output logic o_work_we,
    output logic [DATA_W-1:0] o_work_wdata,
    output logic o_zero_we,
    output logic o_zero,
    output logic o_busy
);
    // Shared arithmetic unit for the four increment and decrement forms
    bids_alu_if alu_bus ();
    bids_alu u_alu (
        .port_a(alu_bus)
    );

    // Decoded instruction
    logic take;
    logic op_jump;
    logic op_arith;
    logic op_skip;
    logic op_dec;
    logic is_jump;
    logic do_arith;
    logic skip_next;
    logic [DATA_W-1:0] result_ext;

    // Sequencer
    bids_pkg::bids_state_e state;
    bids_pkg::bids_state_e next_state;

    // Program counter load
    logic next_pc_load;
    logic [bids_pkg::PC_W-1:0] next_pc;

    // File register write port
    logic next_file_we;
    logic [bids_pkg::FADDR_W-1:0] next_file_addr;
    logic [DATA_W-1:0] next_file_wdata;

    // Working register write port
    logic next_work_we;
    logic [DATA_W-1:0] next_work_wdata;

    // Zero flag update
    logic next_zero_we;
    logic next_zero;

    // Nothing is taken in the squash cycle, so a dropped instruction has no side effects
    assign take = i_issue && (state == bids_pkg::BIDS_ST_EXEC);

    always_comb begin
        op_jump = 1'b0;
        op_arith = 1'b0;
        op_skip = 1'b0;
        op_dec = 1'b0;
        case (i_op)
            bids_pkg::BIDS_OP_JUMP: begin
                op_jump = 1'b1;
            end
            bids_pkg::BIDS_OP_DEC: begin
                op_arith = 1'b1;
                op_dec = 1'b1;
            end
            bids_pkg::BIDS_OP_INC: begin
                op_arith = 1'b1;
            end
            bids_pkg::BIDS_OP_DEC_SKIP: begin
                op_arith = 1'b1;
                op_skip = 1'b1;
                op_dec = 1'b1;
            end
            bids_pkg::BIDS_OP_INC_SKIP: begin
                op_arith = 1'b1;
                op_skip = 1'b1;
            end
            default: begin
                // No-operation and unused codes change nothing
                op_arith = 1'b0;
            end
        endcase
    end

    assign is_jump = take && op_jump;
    assign do_arith = take && op_arith;
    assign alu_bus.operand = i_file_data[bids_pkg::DATA_W-1:0];
    assign alu_bus.decrement = op_dec;
    // Carry out of the unit is dropped, so both directions wrap at 256
    assign result_ext = DATA_W'(alu_bus.result);
    assign skip_next = do_arith && op_skip && alu_bus.is_zero;

    always_comb begin
        next_state = state;
        case (state)
            bids_pkg::BIDS_ST_FLUSH: begin
                // The instruction issued now is discarded; wait here until one arrives
                if (i_issue) begin
                    next_state = bids_pkg::BIDS_ST_EXEC;
                end
            end
            bids_pkg::BIDS_ST_EXEC: begin
                if (is_jump) begin
                    next_state = bids_pkg::BIDS_ST_FLUSH;
                end else if (skip_next) begin
                    next_state = bids_pkg::BIDS_ST_FLUSH;
                end else begin
                    next_state = bids_pkg::BIDS_ST_EXEC;
                end
            end
            default: begin
                next_state = bids_pkg::BIDS_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state <= bids_pkg::BIDS_ST_EXEC;
        end else if (i_enable) begin
            state <= next_state;
        end
    end

    always_comb begin
        next_pc_load = 1'b0;
        next_pc = o_program_counter;
        if (is_jump) begin
            next_pc_load = 1'b1;
            next_pc[bids_pkg::LIT_W-1:0] = i_literal;
            next_pc[bids_pkg::PC_W-1:bids_pkg::LIT_W] =
                i_pc_upper_latch[bids_pkg::LATCH_HI:bids_pkg::LATCH_LO];
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_pc_load <= 1'b0;
            o_program_counter <= bids_pkg::PC_RESET;
        end else if (i_enable) begin
            o_pc_load <= next_pc_load;
            o_program_counter <= next_pc;
        end
    end

    always_comb begin
        next_file_we = 1'b0;
        next_file_addr = o_file_addr;
        next_file_wdata = o_file_wdata;
        if (do_arith) begin
            // Address and data follow every arithmetic form; only the strobe picks the target
            next_file_addr = i_file_addr;
            next_file_wdata = result_ext;
            next_file_we = i_dest_file;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_file_we <= 1'b0;
            o_file_addr <= '0;
            o_file_wdata <= '0;
        end else if (i_enable) begin
            o_file_we <= next_file_we;
            o_file_addr <= next_file_addr;
            o_file_wdata <= next_file_wdata;
        end
    end

    always_comb begin
        next_work_we = 1'b0;
        next_work_wdata = o_work_wdata;
        if (do_arith) begin
            next_work_wdata = result_ext;
            next_work_we = !i_dest_file;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_work_we <= 1'b0;
            o_work_wdata <= '0;
        end else if (i_enable) begin
            o_work_we <= next_work_we;
            o_work_wdata <= next_work_wdata;
        end
    end

    always_comb begin
        next_zero_we = 1'b0;
        next_zero = o_zero;
        // Skip forms and the jump leave the flag alone
        if (do_arith && !op_skip) begin
            next_zero_we = 1'b1;
            next_zero = alu_bus.is_zero;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_zero_we <= 1'b0;
            o_zero <= 1'b0;
        end else if (i_enable) begin
            o_zero_we <= next_zero_we;
            o_zero <= next_zero;
        end
    end

    // Squash marker tells fetch that the instruction issued now is dropped
    assign o_flush = (state == bids_pkg::BIDS_ST_FLUSH);
    // Busy is the squash marker itself, held until the instruction to be dropped is issued
    assign o_busy = o_flush;
endmodule

// *** sim/bids_file_model.sv ***
// Purpose: File register model feeding the executor
// Assumes: Combinational read, write on the rising edge
// Notes: Seeded so address 0 reads FF and address 1 reads 01
`timescale 1ns/1ps
module bids_file_model (
    input wire logic i_clock, i_we,
    input wire logic [6:0] i_waddr, i_raddr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [128];
    initial for (int k = 0; k < 128; k++) mem[k] = 8'(2 * k - 1);
    // Plain always: the cells are also seeded by the initial block
    always @(posedge i_clock) if (i_we) mem[i_waddr] <= i_wdata;
    assign o_rdata = mem[i_raddr];
endmodule

// *** sim/bids_exec_properties.sv ***
// Purpose: Port checks for bids_exec
// Assumes: One clock, async high reset
// Notes: Results land one cycle after the taking edge
`timescale 1ns/1ps
module bids_exec_properties #(parameter int DATA_W = 8) (
    input wire logic i_clock, i_rst, i_enable, i_issue, i_dest_file,
    input wire bids_pkg::bids_op_e i_op,
    input wire logic [10:0] i_literal,
    input wire logic [6:0] i_file_addr, o_file_addr,
    input wire logic [DATA_W-1:0] i_file_data, o_file_wdata, o_work_wdata,
    input wire logic [7:0] i_pc_upper_latch,
    input wire logic o_pc_load, o_flush, o_file_we, o_work_we, o_zero_we, o_zero, o_busy,
    input wire logic [12:0] o_program_counter
);
    logic tk, jp, ar, sk, rz;
    logic [DATA_W-1:0] r;
    logic [1:0] hi;
    assign tk = i_enable & i_issue & ~o_flush;
    assign jp = tk && i_op == bids_pkg::BIDS_OP_JUMP;
    assign ar = tk && i_op > bids_pkg::BIDS_OP_JUMP;
    assign sk = tk && i_op > bids_pkg::BIDS_OP_INC;
    // Bit 0 of the op code marks the increment forms
    assign r = i_op[0] ? i_file_data + 8'h01 : i_file_data - 8'h01;
    assign rz = r == '0;
    assign hi = i_pc_upper_latch[4:3];
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    property p_jpc; jp |=> o_program_counter == {$past(hi), $past(i_literal)}; endproperty
    a_jpc: assert property (p_jpc) else $error("jump target");
    property p_pcl; !jp && i_enable |=> !o_pc_load; endproperty
    a_pcl: assert property (p_pcl) else $error("stray load");
    property p_jfl; jp |=> o_pc_load && o_busy && !o_zero_we && !o_work_we; endproperty
    a_jfl: assert property (p_jfl) else $error("jump effects");
    property p_wrf; ar && i_dest_file |=> o_file_we && !o_work_we && o_file_wdata == $past(r); endproperty
    a_wrf: assert property (p_wrf) else $error("file result");
    property p_wrw; ar && !i_dest_file |=> o_work_we && !o_file_we && o_work_wdata == $past(r); endproperty
    a_wrw: assert property (p_wrw) else $error("work result");
    property p_zf; ar && !sk |=> o_zero_we && o_zero == $past(rz); endproperty
    a_zf: assert property (p_zf) else $error("zero flag");
    property p_skz; sk |=> !o_zero_we && o_flush == $past(rz); endproperty
    a_skz: assert property (p_skz) else $error("skip");
    property p_drop; o_flush && i_enable && i_issue |=> !o_flush && !o_pc_load && !o_file_we; endproperty
    a_drop: assert property (p_drop) else $error("squash");
endmodule
bind bids_exec bids_exec_properties #(.DATA_W(DATA_W)) i_bids_exec_properties (
    .i_clock(i_clock), .i_rst(i_rst), .i_enable(i_enable), .i_issue(i_issue),
    .i_dest_file(i_dest_file), .i_op(i_op), .i_literal(i_literal),
    .i_file_addr(i_file_addr), .o_file_addr(o_file_addr), .i_file_data(i_file_data),
    .o_file_wdata(o_file_wdata), .o_work_wdata(o_work_wdata),
    .i_pc_upper_latch(i_pc_upper_latch), .o_pc_load(o_pc_load), .o_flush(o_flush),
    .o_file_we(o_file_we), .o_work_we(o_work_we), .o_zero_we(o_zero_we), .o_zero(o_zero),
    .o_busy(o_busy), .o_program_counter(o_program_counter)
);

// *** sim/branch_incdec_skip_exec_bench.sv ***
// Purpose: Corner and random checks of bids_exec against a bench reference
// Assumes: Inputs change at the falling edge, outputs compared one cycle later
// Notes: Small addresses are favoured so wrap and zero cases recur
`timescale 1ns/1ps
module branch_incdec_skip_exec_bench;
    logic i_clock = 0, i_rst = 1, i_enable = 0, i_issue = 0, i_dest_file = 0;
    bids_pkg::bids_op_e i_op = bids_pkg::BIDS_OP_NONE;
    logic [10:0] i_literal = '0;
    logic [6:0] i_file_addr = '0, o_file_addr, e_fa = '0;
    logic [7:0] i_file_data, i_pc_upper_latch = '0, o_file_wdata, o_work_wdata, e_fd = '0, e_wd = '0;
    logic o_pc_load, o_flush, o_file_we, o_work_we, o_zero_we, o_zero, o_busy;
    logic e_pcl = 0, e_fl = 0, e_fwe = 0, e_wwe = 0, e_zwe = 0, e_z = 0;
    logic [12:0] o_program_counter, e_pc = '0;
    logic [15:0] rs = 16'h49BC;
    int bad_count = 0, tests_run = 0;
    always #12.5 i_clock = ~i_clock;
    bids_exec i_bids_exec (
        .i_clock(i_clock), .i_rst(i_rst), .i_enable(i_enable), .i_issue(i_issue),
        .i_op(i_op), .i_literal(i_literal), .i_file_addr(i_file_addr),
        .i_dest_file(i_dest_file), .i_file_data(i_file_data),
        .i_pc_upper_latch(i_pc_upper_latch), .o_pc_load(o_pc_load),
        .o_program_counter(o_program_counter), .o_flush(o_flush), .o_file_we(o_file_we),
        .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata), .o_work_we(o_work_we),
        .o_work_wdata(o_work_wdata), .o_zero_we(o_zero_we), .o_zero(o_zero), .o_busy(o_busy)
    );
    bids_file_model i_bids_file_model (.i_clock(i_clock), .i_we(o_file_we), .i_waddr(o_file_addr),
        .i_raddr(i_file_addr), .i_wdata(o_file_wdata), .o_rdata(i_file_data));
    function automatic logic [15:0] xs(input logic [15:0] s);
        s = s ^ (s << 7);
        s = s ^ (s >> 9);
        return s ^ (s << 8);
    endfunction
    // Reference arithmetic: one up for the increment forms, one down otherwise, wrapping at 256
    function automatic logic [7:0] ref_result(input bids_pkg::bids_op_e op, input logic [7:0] f);
        if (op == bids_pkg::BIDS_OP_INC || op == bids_pkg::BIDS_OP_INC_SKIP)
            return f + 8'h01;
        return f - 8'h01;
    endfunction
    function automatic logic [12:0] ref_target(input logic [7:0] latch, input logic [10:0] lit);
        return {latch[4:3], lit};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic step(input bids_pkg::bids_op_e op, input logic [6:0] a, input logic d, iss, en);
        logic [7:0] r;
        i_op = op;
        {i_file_addr, i_dest_file, i_issue, i_enable} = {a, d, iss, en};
        i_literal = rs[10:0];
        i_pc_upper_latch = rs[15:8];
        rs = xs(rs);
        #1 r = ref_result(op, i_file_data);
        @(posedge i_clock);
        if (en) begin
            {e_pcl, e_fwe, e_wwe, e_zwe} = 4'h0;
            if (iss && e_fl) e_fl = 1'b0;
            else if (iss && op == bids_pkg::BIDS_OP_JUMP)
                {e_pcl, e_fl, e_pc} = {2'b11, ref_target(i_pc_upper_latch, i_literal)};
            else if (iss && op > bids_pkg::BIDS_OP_JUMP) begin
                // Address and data follow every arithmetic form; only the strobe picks the target
                {e_fa, e_fd, e_wd} = {a, r, r};
                if (d) e_fwe = 1'b1;
                else e_wwe = 1'b1;
                if (op > bids_pkg::BIDS_OP_INC) e_fl = r == 8'h00;
                else {e_zwe, e_z} = {1'b1, r == 8'h00};
            end
        end
        @(negedge i_clock);
        chk({o_pc_load, o_flush, o_busy, o_program_counter}, {e_pcl, e_fl, e_fl, e_pc});
        chk({o_file_we, o_file_addr, o_file_wdata, o_work_we, o_work_wdata},
            {e_fwe, e_fa, e_fd, e_wwe, e_wd});
        chk({o_zero_we, o_zero}, {e_zwe, e_z});
    endtask
    initial begin
        repeat (16) @(posedge i_clock);
        @(negedge i_clock);
        i_rst = 0;
        // Back to back on the FF and 01 cells: wraps, zero skips, squashed jumps
        for (int k = 0; k < 20; k++)
            step(bids_pkg::bids_op_e'(3'(k / 4 + 1)), 7'(k % 2), k[1], 1'b1, 1'b1);
        // Cell 0 now holds 00: wrap down to FF, let the write land, then plain wrap up to zero
        step(bids_pkg::BIDS_OP_DEC, 7'h00, 1'b1, 1'b1, 1'b1);
        step(bids_pkg::BIDS_OP_NONE, 7'h00, 1'b0, 1'b1, 1'b1);
        step(bids_pkg::BIDS_OP_INC, 7'h00, 1'b1, 1'b1, 1'b1);
        $display("corner steps done");
        repeat (2000) step(bids_pkg::bids_op_e'(3'(rs % 6)), rs[9] ? rs[6:0] : {5'h00, rs[1:0]},
            rs[4], rs[3] | rs[2], rs[7:5] != 3'h0);
        $display("random steps done");
        tally_and_finish();
    end
    initial begin
        repeat (3000) @(posedge i_clock);
        bad_count++;
        tally_and_finish();
    end
endmodule
